//--- rtl/flag_bank.sv
// One bank of set/clear flag bits with one shared storage
`timescale 1ns/100ps
`default_nettype none
module flag_bank #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Update strobes
    input wire logic [WIDTH-1:0] set_bits,
    input wire logic [WIDTH-1:0] clr_bits,
    // State
    output logic [WIDTH-1:0] flags
);
    if (WIDTH < 1) begin : g_bad_width
        $error("flag_bank needs WIDTH of at least 1");
    end

    logic [WIDTH-1:0] flags_r;
    logic [WIDTH-1:0] flags_nxt;

    // Set wins over clear so a coincident event is never lost
    assign flags_nxt = (flags_r & ~clr_bits) | set_bits;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;
endmodule : flag_bank
`default_nettype wire

//--- rtl/ovf_irq_map.svh
// Register offsets, field positions, counter count, reset values and valid mask for the overflow interrupt bank
`ifndef OVF_IRQ_MAP_SVH
`define OVF_IRQ_MAP_SVH

`define OFS_OVERFLOW_SET        12'h000
`define OFS_OVERFLOW_CLEAR      12'h004
`define OFS_IRQ_ENABLE_SET      12'h008
`define OFS_IRQ_ENABLE_CLEAR    12'h00C
`define OFS_OVERFLOW_EVENT      12'h010

`define BIT_CYCLE               31
`define NUM_EVENT_COUNTERS      4
`define RESET_ENABLE            5'h00
`define RESET_OVERFLOW          5'h00
`define VALID_MASK              32'h8000000F

`endif

//--- rtl/ovf_irq_pkg.sv
// Types shared by the overflow interrupt bank
package ovf_irq_pkg;
    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_OVS_SET = 3'h1,
        REG_OVS_CLR = 3'h2,
        REG_INT_SET = 3'h3,
        REG_INT_CLR = 3'h4,
        REG_OVS_EVT = 3'h5
    } reg_sel_type;
endpackage : ovf_irq_pkg

//--- rtl/pmu_overflow_irq_enable.sv
// APB register bank for counter overflow flags and overflow interrupt enables
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ovf_irq_map.svh"

module pmu_overflow_irq_enable #(
    parameter int NUM_EVENTS = `NUM_EVENT_COUNTERS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Overflow events from the counters, one-cycle pulses on pclk
    input wire logic cycle_overflow_event,
    input wire logic [NUM_EVENTS-1:0] event_overflow_event,
    // Interrupt request
    output logic overflow_irq
);
    if (NUM_EVENTS != `NUM_EVENT_COUNTERS) begin : g_bad_events
        $error("pmu_overflow_irq_enable serves exactly four event counters");
    end

    localparam int W = NUM_EVENTS + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    ovf_irq_pkg::reg_sel_type sel;
    logic access;
    logic wr_en;
    logic rd_en;

    always_comb begin
        unique case (paddr)
            `OFS_OVERFLOW_SET: sel = ovf_irq_pkg::REG_OVS_SET;
            `OFS_OVERFLOW_CLEAR: sel = ovf_irq_pkg::REG_OVS_CLR;
            `OFS_IRQ_ENABLE_SET: sel = ovf_irq_pkg::REG_INT_SET;
            `OFS_IRQ_ENABLE_CLEAR: sel = ovf_irq_pkg::REG_INT_CLR;
            `OFS_OVERFLOW_EVENT: sel = ovf_irq_pkg::REG_OVS_EVT;
            default: sel = ovf_irq_pkg::REG_NONE;
        endcase
    end

    // Zero-wait slave; every access ends in its first access cycle
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && (sel == ovf_irq_pkg::REG_NONE);
    assign wr_en = access && pwrite && (sel != ovf_irq_pkg::REG_NONE);
    assign rd_en = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // Write data packing: bit 31 goes to the top of the compact vector

    logic [W-1:0] ovf_event;
    logic [W-1:0] wbits;
    logic [W-1:0] ovf_set;
    logic [W-1:0] ovf_clr;
    logic [W-1:0] ena_set;
    logic [W-1:0] ena_clr;

    // Reserved bits 30:4 never reach the store
    always_comb begin
        wbits = '0;
        if (pstrb[3]) wbits[W-1] = pwdata[`BIT_CYCLE];
        if (pstrb[0]) wbits[NUM_EVENTS-1:0] = pwdata[NUM_EVENTS-1:0];
    end

    assign ovf_event = {cycle_overflow_event, event_overflow_event};
    assign ovf_set = ovf_event
        | ((wr_en && sel == ovf_irq_pkg::REG_OVS_SET) ? wbits : '0);
    // A write of zero selects nothing, so the flag holds
    assign ovf_clr = (wr_en && sel == ovf_irq_pkg::REG_OVS_CLR) ? wbits : '0;
    // Ones enable, zeros leave the enable alone
    assign ena_set = (wr_en && sel == ovf_irq_pkg::REG_INT_SET) ? wbits : '0;
    // Ones disable the matching request
    assign ena_clr = (wr_en && sel == ovf_irq_pkg::REG_INT_CLR) ? wbits : '0;

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [W-1:0] ovf_flags;
    logic [W-1:0] ena_flags;

    flag_bank #(
        .WIDTH(W)
    ) u_overflow (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(ovf_set),
        .clr_bits(ovf_clr),
        .flags(ovf_flags)
    );

    // One shared store for both enable views, reset to all off
    flag_bank #(
        .WIDTH(W)
    ) u_enable (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(ena_set),
        .clr_bits(ena_clr),
        .flags(ena_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    function automatic logic [31:0] spread(input logic [W-1:0] v);
        logic [31:0] r;
        r = 32'h00000000;
        r[`BIT_CYCLE] = v[W-1];
        r[NUM_EVENTS-1:0] = v[NUM_EVENTS-1:0];
        return r;
    endfunction : spread

    logic [31:0] prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (rd_en) begin
            unique case (sel)
                ovf_irq_pkg::REG_OVS_SET,
                ovf_irq_pkg::REG_OVS_CLR: prdata_r <= spread(ovf_flags);
                ovf_irq_pkg::REG_INT_SET,
                ovf_irq_pkg::REG_INT_CLR: prdata_r <= spread(ena_flags);
                ovf_irq_pkg::REG_OVS_EVT: prdata_r <= spread(ovf_flags & ena_flags);
                ovf_irq_pkg::REG_NONE: prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output, registered to keep it glitch free

    logic irq_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ovf_flags & ena_flags);
        end
    end

    assign overflow_irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_ovf_clear_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel == ovf_irq_pkg::REG_OVS_CLR && pstrb[0] && pwdata[0]
         && !event_overflow_event[0]) |=> !ovf_flags[0])
        else $error("overflow flag 0 not cleared by write one");

    chk_ovf_zero_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel == ovf_irq_pkg::REG_OVS_CLR && !pwdata[1] && ovf_flags[1])
        |=> ovf_flags[1])
        else $error("overflow flag 1 lost on write of zero");

    chk_ovf_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && sel == ovf_irq_pkg::REG_OVS_CLR) |=>
        (prdata[0] == $past(ovf_flags[0]) && prdata[31] == $past(ovf_flags[W-1])))
        else $error("overflow clear read mismatch");

    chk_ena_cycle_set: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel == ovf_irq_pkg::REG_INT_SET && pstrb[3] && pwdata[31])
        |=> ena_flags[W-1])
        else $error("cycle enable not set");

    chk_ena_event_set: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel == ovf_irq_pkg::REG_INT_SET && pstrb[0] && pwdata[2])
        |=> ena_flags[2])
        else $error("event 2 enable not set");

    chk_ena_zero_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel == ovf_irq_pkg::REG_INT_SET && pwdata[3:0] == 4'h0)
        |=> ena_flags[NUM_EVENTS-1:0] == $past(ena_flags[NUM_EVENTS-1:0]))
        else $error("enable changed on write of zero");

    chk_ena_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel == ovf_irq_pkg::REG_INT_CLR && pstrb[3] && pwdata[31])
        |=> !ena_flags[W-1])
        else $error("cycle enable not cleared");

    chk_ena_same_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && (sel == ovf_irq_pkg::REG_INT_SET || sel == ovf_irq_pkg::REG_INT_CLR))
        |=> (prdata == spread($past(ena_flags)) && prdata[30:4] == 27'h0))
        else $error("enable read mismatch");

    chk_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
        overflow_irq == $past(|(ovf_flags & ena_flags)))
        else $error("interrupt does not follow flags and enables");

    chk_reset_state: assert property (@(posedge pclk)
        $rose(presetn) |-> (ena_flags == '0 && ovf_flags == '0))
        else $error("state not zero after reset");

    chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[`BIT_CYCLE-1:NUM_EVENTS] == '0)
        else $error("reserved read bits not zero");

    chk_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_en |=> $stable(prdata))
        else $error("read data moved outside a read setup");

    chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && sel == ovf_irq_pkg::REG_NONE) |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    chk_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && sel == ovf_irq_pkg::REG_NONE) |=> $stable(ena_flags))
        else $error("unmapped write changed the enables");

    chk_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !access |-> !pslverr)
        else $error("error answer outside an access cycle");

    chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (access && sel == ovf_irq_pkg::REG_NONE) |-> pslverr)
        else $error("unmapped access without error answer");

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit checks; POS is the bus bit and LANE its strobe for compact bit i

    for (genvar i = 0; i < W; i++) begin : g_bit_chk
        localparam int POS = (i == W - 1) ? `BIT_CYCLE : i;
        localparam int LANE = POS / 8;

        // Overflow flags
        chk_bit_w1c: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && sel == ovf_irq_pkg::REG_OVS_CLR && pstrb[LANE] && pwdata[POS]
             && !ovf_event[i])
            |=> !ovf_flags[i])
            else $error("overflow flag not cleared by write one");

        chk_bit_w0_hold: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && sel == ovf_irq_pkg::REG_OVS_CLR && !(pstrb[LANE] && pwdata[POS])
             && ovf_flags[i])
            |=> ovf_flags[i])
            else $error("overflow flag lost on write of zero");

        chk_bit_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
            (ovf_event[i] && ovf_clr[i])
            |=> ovf_flags[i])
            else $error("counter overflow lost to a coincident clear");

        chk_bit_event_set: assert property (@(posedge pclk) disable iff (!presetn)
            ovf_event[i]
            |=> ovf_flags[i])
            else $error("counter overflow did not set its flag");

        chk_bit_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && sel == ovf_irq_pkg::REG_OVS_SET && pstrb[LANE]
             && pwdata[POS])
            |=> ovf_flags[i])
            else $error("overflow flag not set by write one");

        // Enable store
        chk_bit_ena_set: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && sel == ovf_irq_pkg::REG_INT_SET && pstrb[LANE]
             && pwdata[POS])
            |=> ena_flags[i])
            else $error("enable not set by write one");

        chk_bit_ena_zero: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && sel == ovf_irq_pkg::REG_INT_SET
             && !(pstrb[LANE] && pwdata[POS]))
            |=> ena_flags[i] == $past(ena_flags[i]))
            else $error("enable changed by write of zero");

        chk_bit_ena_clr: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && sel == ovf_irq_pkg::REG_INT_CLR && pstrb[LANE]
             && pwdata[POS])
            |=> !ena_flags[i])
            else $error("enable not cleared by write one");

        chk_bit_ena_hold: assert property (@(posedge pclk) disable iff (!presetn)
            !(wr_en && (sel == ovf_irq_pkg::REG_INT_SET
                        || sel == ovf_irq_pkg::REG_INT_CLR))
            |=> $stable(ena_flags[i]))
            else $error("enable moved without a set or clear write");

        // Read views and interrupt
        chk_bit_ena_read: assert property (@(posedge pclk) disable iff (!presetn)
            (rd_en && (sel == ovf_irq_pkg::REG_INT_SET
                       || sel == ovf_irq_pkg::REG_INT_CLR))
            |=> prdata[POS] == $past(ena_flags[i]))
            else $error("enable read bit mismatch");

        chk_bit_ovf_read: assert property (@(posedge pclk) disable iff (!presetn)
            (rd_en && (sel == ovf_irq_pkg::REG_OVS_SET
                       || sel == ovf_irq_pkg::REG_OVS_CLR))
            |=> prdata[POS] == $past(ovf_flags[i]))
            else $error("overflow read bit mismatch");

        chk_bit_status_read: assert property (@(posedge pclk) disable iff (!presetn)
            (rd_en && sel == ovf_irq_pkg::REG_OVS_EVT)
            |=> prdata[POS] == $past(ovf_flags[i] && ena_flags[i]))
            else $error("status read bit mismatch");

        chk_bit_irq_up: assert property (@(posedge pclk) disable iff (!presetn)
            (ovf_flags[i] && ena_flags[i])
            |=> overflow_irq)
            else $error("enabled overflow without interrupt");
    end

    cov_enable_set: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel == ovf_irq_pkg::REG_INT_SET);
    cov_enable_clear: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel == ovf_irq_pkg::REG_INT_CLR);
    cov_irq_raised: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(overflow_irq));
    cov_clear_race: cover property (@(posedge pclk) disable iff (!presetn)
        |(ovf_set & ovf_clr));
    cov_status_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_en && sel == ovf_irq_pkg::REG_OVS_EVT);
endmodule : pmu_overflow_irq_enable
`default_nettype wire

//--- tb/tb.sv
// Self-checking APB testbench for the overflow interrupt enable bank
`timescale 1ns/100ps
`default_nettype none
`include "ovf_irq_map.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cyc_ev, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb, evt_ev, race_ev;
    int err_count, compares;

    pmu_overflow_irq_enable #(.NUM_EVENTS(4)) i_pmu_overflow_irq_enable (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cycle_overflow_event(cyc_ev), .event_overflow_event(evt_ev),
        .overflow_irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task results;
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    // Entered right after a rising edge; one idle cycle follows so psel never toggles twice
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        evt_ev <= race_ev;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        evt_ev <= 4'h0;
        @(posedge pclk);
    endtask : apb

    // Interrupt is registered: look at it half a cycle after the edge that launches it
    task irq_chk(input string name, input logic exp);
        @(negedge pclk);
        chk(name, {31'h0, exp}, {31'h0, irq});
        @(posedge pclk);
    endtask : irq_chk

    task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rdata);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        cyc_ev = 1'b0;
        evt_ev = 4'h0;
        race_ev = 4'h0;
        err_count = 0;
        compares = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("enable_set_reset", `OFS_IRQ_ENABLE_SET, 32'h0000_0000);
        rd_chk("enable_clear_reset", `OFS_IRQ_ENABLE_CLEAR, 32'h0000_0000);
        rd_chk("overflow_reset", `OFS_OVERFLOW_CLEAR, 32'h0000_0000);
        // Reserved bits written as ones must not stick
        apb(1'b1, `OFS_IRQ_ENABLE_SET, 32'hFFFF_FFFF);
        rd_chk("enable_set_all", `OFS_IRQ_ENABLE_SET, 32'h8000_000F);
        rd_chk("enable_clear_view", `OFS_IRQ_ENABLE_CLEAR, 32'h8000_000F);
        apb(1'b1, `OFS_IRQ_ENABLE_SET, 32'h0000_0000);
        rd_chk("enable_set_zero", `OFS_IRQ_ENABLE_SET, 32'h8000_000F);
        apb(1'b1, `OFS_IRQ_ENABLE_CLEAR, 32'h8000_0001);
        rd_chk("enable_after_clear", `OFS_IRQ_ENABLE_SET, 32'h0000_000E);
        irq_chk("irq_no_flags", 1'b0);
        cyc_ev <= 1'b1;
        evt_ev <= 4'h3;
        @(posedge pclk);
        cyc_ev <= 1'b0;
        evt_ev <= 4'h0;
        rd_chk("overflow_flags", `OFS_OVERFLOW_CLEAR, 32'h8000_0003);
        irq_chk("irq_event1", 1'b1);
        apb(1'b1, `OFS_OVERFLOW_CLEAR, 32'h0000_0000);
        rd_chk("overflow_w0", `OFS_OVERFLOW_CLEAR, 32'h8000_0003);
        apb(1'b1, `OFS_OVERFLOW_CLEAR, 32'h0000_0002);
        rd_chk("overflow_w1c", `OFS_OVERFLOW_CLEAR, 32'h8000_0001);
        irq_chk("irq_masked", 1'b0);
        apb(1'b1, `OFS_IRQ_ENABLE_SET, 32'h0000_0001);
        irq_chk("irq_event0", 1'b1);
        apb(1'b1, `OFS_OVERFLOW_CLEAR, 32'h0000_0001);
        rd_chk("overflow_bit0", `OFS_OVERFLOW_CLEAR, 32'h8000_0000);
        irq_chk("irq_cleared", 1'b0);
        // Unmapped offset: error answer, nothing stored
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        chk("pslverr_write", 32'h1, {31'h0, rerr});
        rd_chk("unmapped_read", 12'h020, 32'h0000_0000);
        chk("pslverr_read", 32'h1, {31'h0, rerr});
        rd_chk("enable_untouched", `OFS_IRQ_ENABLE_CLEAR, 32'h0000_000F);
        // Software set of a flag, then the flag-and-enable status view
        apb(1'b1, `OFS_OVERFLOW_SET, 32'h0000_0004);
        rd_chk("overflow_set_view", `OFS_OVERFLOW_SET, 32'h8000_0004);
        rd_chk("status_view", `OFS_OVERFLOW_EVENT, 32'h0000_0004);
        irq_chk("irq_event2", 1'b1);
        // Byte strobes: lane 3 alone sets bit 31, lane 0 alone clears bits 3:0
        pstrb <= 4'h8;
        apb(1'b1, `OFS_IRQ_ENABLE_SET, 32'hFFFF_FFFF);
        pstrb <= 4'h1;
        apb(1'b1, `OFS_IRQ_ENABLE_CLEAR, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        rd_chk("enable_strobes", `OFS_IRQ_ENABLE_SET, 32'h8000_0000);
        irq_chk("irq_cycle", 1'b1);
        apb(1'b1, `OFS_OVERFLOW_CLEAR, 32'h8000_0004);
        rd_chk("overflow_all_clear", `OFS_OVERFLOW_CLEAR, 32'h0000_0000);
        irq_chk("irq_idle", 1'b0);
        // Counter overflow in the same cycle as a clear of that flag: the event wins
        race_ev = 4'h1;
        apb(1'b1, `OFS_OVERFLOW_CLEAR, 32'h0000_0001);
        race_ev = 4'h0;
        rd_chk("set_wins_clear", `OFS_OVERFLOW_CLEAR, 32'h0000_0001);
        // Reset in mid-run brings every flag and enable back to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("enable_rerun_reset", `OFS_IRQ_ENABLE_CLEAR, 32'h0000_0000);
        rd_chk("overflow_rerun_reset", `OFS_OVERFLOW_CLEAR, 32'h0000_0000);
        irq_chk("irq_rerun_reset", 1'b0);
        results();
    end
endmodule : tb
`default_nettype wire
